// file: src/dlw_pkg.sv
// Shared constants for the drive limit and warning supervisor
package dlw_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_CATCH_PCT = 8'h04;
   localparam logic [7:0] OFS_CUR_CAP   = 8'h08;
   localparam logic [7:0] OFS_RATED_CUR = 8'h0c;
   localparam logic [7:0] OFS_CUR_LOW   = 8'h10;
   localparam logic [7:0] OFS_CUR_HIGH  = 8'h14;
   localparam logic [7:0] OFS_FREQ_LOW  = 8'h18;
   localparam logic [7:0] OFS_FREQ_HIGH = 8'h1c;
   localparam logic [7:0] OFS_FEEDBACK_WARN_FLOOR    = 8'h20;
   localparam logic [7:0] OFS_FEEDBACK_WARN_CEILING   = 8'h24;
   localparam logic [7:0] OFS_BYP_WIDTH = 8'h28;
   localparam logic [7:0] OFS_BYP1      = 8'h2c;
   localparam logic [7:0] OFS_BYP2      = 8'h30;
   localparam logic [7:0] OFS_ROUTE_DO  = 8'h34;
   localparam logic [7:0] OFS_ROUTE_REL = 8'h38;
   localparam logic [7:0] OFS_STATUS    = 8'h3c;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h40;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h44;

   // Field positions
   localparam int CTRL_WIDE_BIT  = 0;
   localparam int STAT_RUN_BIT   = 6;
   localparam int STAT_ATREF_BIT = 7;
   localparam int NUM_WARN       = 6;

   // Scales: catch-up percent in 0.01 %, current cap percent in 1 %, frequency in 0.1 Hz, current in 0.1 A
   localparam logic [13:0] PCT_FULL_SCALE = 14'h2710;
   localparam logic [15:0] CAP_PCT_UNIT   = 16'h0064;

   // Reset values
   localparam logic [13:0] RST_CATCH_PCT  = 14'h0000;
   localparam logic [15:0] RST_CUR_CAP    = 16'h00a0;
   localparam logic [15:0] RST_RATED_CUR  = 16'h0064;
   localparam logic [15:0] RST_CUR_LOW    = 16'h0000;
   localparam logic [15:0] RST_CUR_HIGH   = 16'hffff;
   localparam logic [15:0] RST_FREQ_LOW   = 16'h0000;
   localparam logic [15:0] RST_FREQ_HIGH  = 16'h0528;
   localparam logic [31:0] RST_FEEDBACK_WARN_FLOOR     = 32'hffc2_f700;
   localparam logic [31:0] RST_FEEDBACK_WARN_CEILING    = 32'h003d_0900;
   localparam logic [15:0] RST_BYP_WIDTH  = 16'h0000;
   localparam logic [15:0] RST_BYP        = 16'h0000;

   // Limits
   localparam logic [15:0] FREQ_MAX_NARROW = 16'h0528;
   localparam logic [15:0] FREQ_MAX_WIDE   = 16'h2710;
   localparam logic [15:0] BYP_WIDTH_MAX   = 16'h03e8;
   localparam logic [15:0] BYP_FREQ_MAX    = 16'h2710;
   localparam logic [31:0] FB_MIN          = 32'ha0f0_4500;
   localparam logic [31:0] FB_MAX          = 32'h5f5e_1000;
endpackage

// file: src/dlw_limit_compare.sv
// Low and high threshold comparator with registered warning outputs
`timescale 1ns/10ps
`default_nettype none
module dlw_limit_compare (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   // Compare inputs
   input  wire logic signed [31:0] value,
   input  wire logic signed [31:0] lowLim,
   input  wire logic signed [31:0] highLim,
   input  wire logic               evalEn,
   // Warnings
   output logic                    lowWarn,
   output logic                    highWarn
);
   typedef struct packed {
      logic lowWarn;
      logic highWarn;
   } dlw_cmp_state_t;

   dlw_cmp_state_t st_r;
   dlw_cmp_state_t st_nxt;

   always_comb begin
      st_nxt          = st_r;
      st_nxt.lowWarn  = evalEn && (value < lowLim);
      st_nxt.highWarn = evalEn && (value > highLim);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lowWarn  = st_r.lowWarn;
   assign highWarn = st_r.highWarn;
endmodule
`default_nettype wire

// file: src/dlw_supervisor.sv
// Drive limit and warning supervisor: reference trim, current cap, warnings, frequency bypass
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Catch-up input raises remote reference by programmed percentage.
// - Slow-down input lowers remote reference by programmed percentage.
// - Output current capped at programmable percent of rated current, default 160.
// - Low-current warning when current below low threshold, default zero.
// - High-current warning when current above high threshold.
// - Low-frequency warning when frequency below low threshold, default zero.
// - High-frequency warning when frequency above high threshold, default 132 Hz.
// - High-frequency threshold spans low threshold to 132 or 1000 Hz.
// - Low-feedback warning when feedback below floor, default minus 4000.
// - High-feedback warning when feedback above ceiling, default plus 4000.
// - All six warnings suppressed during ramp-up, after stop, while stopped.
// - Warning evaluation starts once output frequency reaches resulting reference.
// - Any warning can be routed to digital output and relay.
// - Output frequency kept out of band centred on bypass; zero width disables.
// - Two bypass frequencies, each 0 to 1000 Hz, default zero.
module dlw_supervisor (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Digital input pins
   input  wire logic               catchUpPin,
   input  wire logic               slowDownPin,
   input  wire logic               runPin,
   // Drive measurements and demands
   input  wire logic [15:0]        remoteRef,
   input  wire logic [15:0]        outFreq,
   input  wire logic [15:0]        outCurrent,
   input  wire logic [15:0]        currentDemand,
   input  wire logic signed [31:0] feedback,
   // Results
   output logic [15:0]             resultRef,
   output logic [15:0]             currentCmd,
   output logic [5:0]              warnings,
   output logic                    warnDigitalOut,
   output logic                    warnRelayOut,
   output logic                    irq
);
   typedef struct packed {
      logic        wideRange;
      logic [13:0] catchPct;
      logic [15:0] capPct;
      logic [15:0] ratedCur;
      logic [15:0] curLow;
      logic [15:0] curHigh;
      logic [15:0] freqLow;
      logic [15:0] freqHigh;
      logic [31:0] fbLow;
      logic [31:0] fbHigh;
      logic [15:0] bypWidth;
      logic [15:0] byp1;
      logic [15:0] byp2;
      logic [5:0]  routeDo;
      logic [5:0]  routeRel;
      logic [5:0]  irqStat;
      logic [5:0]  irqMask;
      logic [5:0]  warnPrev;
      logic [2:0]  syncA;
      logic [2:0]  syncB;
      logic        atRef;
      logic [15:0] refOut;
      logic [15:0] curCmd;
      logic        doOut;
      logic        relOut;
      logic [31:0] rdata;
      logic        err;
   } dlw_state_t;

   localparam dlw_state_t ST_RST = '{
      catchPct: dlw_pkg::RST_CATCH_PCT,
      capPct:   dlw_pkg::RST_CUR_CAP,
      ratedCur: dlw_pkg::RST_RATED_CUR,
      curLow:   dlw_pkg::RST_CUR_LOW,
      curHigh:  dlw_pkg::RST_CUR_HIGH,
      freqLow:  dlw_pkg::RST_FREQ_LOW,
      freqHigh: dlw_pkg::RST_FREQ_HIGH,
      fbLow:    dlw_pkg::RST_FEEDBACK_WARN_FLOOR,
      fbHigh:   dlw_pkg::RST_FEEDBACK_WARN_CEILING,
      bypWidth: dlw_pkg::RST_BYP_WIDTH,
      byp1:     dlw_pkg::RST_BYP,
      byp2:     dlw_pkg::RST_BYP,
      default:  '0
   };

   dlw_state_t st_r;
   dlw_state_t st_nxt;

   logic [5:0]         warnLive;
   logic               evalEn;
   logic signed [31:0] cmpVal [3];
   logic signed [31:0] cmpLow [3];
   logic signed [31:0] cmpHigh [3];

   // Unsigned clamp into [lo, hi]
   function automatic logic [15:0] clampU(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
      if (v > {16'h0000, hi}) begin
         clampU = hi;
      end else if (v < {16'h0000, lo}) begin
         clampU = lo;
      end else begin
         clampU = v[15:0];
      end
   endfunction

   // Push a frequency out of the band around one bypass centre
   function automatic logic [15:0] bypass(input logic [15:0] f, input logic [15:0] ctr, input logic [15:0] width);
      logic [15:0] half;
      logic [16:0] lo;
      logic [16:0] hi;
      half = {1'b0, width[15:1]};
      lo   = {1'b0, ctr} - {1'b0, half};
      hi   = {1'b0, ctr} + {1'b0, half};
      bypass = f;
      if (width != 16'h0000 && {1'b0, f} > lo && {1'b0, f} < hi) begin
         if (f < ctr) begin
            bypass = lo[16] ? 16'h0000 : lo[15:0];
         end else begin
            bypass = hi[16] ? 16'hffff : hi[15:0];
         end
      end
   endfunction

   // Channel 0 current, 1 frequency, 2 feedback
   assign cmpVal[0]  = {16'h0000, outCurrent};
   assign cmpLow[0]  = {16'h0000, st_r.curLow};
   assign cmpHigh[0] = {16'h0000, st_r.curHigh};
   assign cmpVal[1]  = {16'h0000, outFreq};
   assign cmpLow[1]  = {16'h0000, st_r.freqLow};
   assign cmpHigh[1] = {16'h0000, st_r.freqHigh};
   assign cmpVal[2]  = feedback;
   assign cmpLow[2]  = st_r.fbLow;
   assign cmpHigh[2] = st_r.fbHigh;

   assign evalEn = st_r.syncB[2] && st_r.atRef;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : gCmp
         dlw_limit_compare uCmp (
            .clk      (clk),
            .rst_b    (rst_b),
            .value    (cmpVal[gi]),
            .lowLim   (cmpLow[gi]),
            .highLim  (cmpHigh[gi]),
            .evalEn   (evalEn),
            .lowWarn  (warnLive[2*gi]),
            .highWarn (warnLive[2*gi+1])
         );
      end
   endgenerate

   always_comb begin
      logic [29:0] prod;
      logic [15:0] delta;
      logic [16:0] trimmed;
      logic [31:0] capAmps;
      logic [15:0] fMax;
      logic        rdSetup;
      logic        wrAcc;
      logic [31:0] rd;
      logic        hit;
      prod    = '0;
      delta   = '0;
      trimmed = '0;
      capAmps = '0;
      fMax    = '0;
      rd      = '0;
      rdSetup = 1'b0;
      wrAcc   = 1'b0;
      hit     = 1'b1;
      st_nxt  = st_r;

      // Pin synchronisers: catch-up, slow-down, run
      st_nxt.syncA = {runPin, slowDownPin, catchUpPin};
      st_nxt.syncB = st_r.syncA;

      // Reference trim, then bypass bands
      prod  = remoteRef * st_r.catchPct;
      delta = 16'((prod + 30'(dlw_pkg::PCT_FULL_SCALE / 2)) / dlw_pkg::PCT_FULL_SCALE);
      if (st_r.syncB[0] && !st_r.syncB[1]) begin
         trimmed = {1'b0, remoteRef} + {1'b0, delta};
      end else if (st_r.syncB[1] && !st_r.syncB[0]) begin
         trimmed = {1'b0, remoteRef} - {1'b0, delta};
      end else begin
         trimmed = {1'b0, remoteRef};
      end
      if (trimmed[16]) begin
         trimmed = 17'h0ffff;
      end
      st_nxt.refOut = bypass(bypass(trimmed[15:0], st_r.byp1, st_r.bypWidth),
                             st_r.byp2, st_r.bypWidth);

      // Current cap
      capAmps = (32'(st_r.ratedCur) * 32'(st_r.capPct)) / 32'(dlw_pkg::CAP_PCT_UNIT);
      st_nxt.curCmd = (32'(currentDemand) > capAmps) ? capAmps[15:0] : currentDemand;

      // Warning enable: cleared while stopped, set on reaching the reference
      if (!st_r.syncB[2]) begin
         st_nxt.atRef = 1'b0;
      end else if (outFreq == st_r.refOut) begin
         st_nxt.atRef = 1'b1;
      end

      st_nxt.doOut    = |(warnLive & st_r.routeDo);
      st_nxt.relOut   = |(warnLive & st_r.routeRel);
      st_nxt.warnPrev = warnLive;

      // APB: decode in setup phase, answer in the access phase
      rdSetup = psel && !penable;
      wrAcc   = psel && penable && pwrite;
      fMax    = st_r.wideRange ? dlw_pkg::FREQ_MAX_WIDE : dlw_pkg::FREQ_MAX_NARROW;
      unique case (paddr)
         dlw_pkg::OFS_CTRL:      rd = {31'h0, st_r.wideRange};
         dlw_pkg::OFS_CATCH_PCT: rd = {18'h0, st_r.catchPct};
         dlw_pkg::OFS_CUR_CAP:   rd = {16'h0, st_r.capPct};
         dlw_pkg::OFS_RATED_CUR: rd = {16'h0, st_r.ratedCur};
         dlw_pkg::OFS_CUR_LOW:   rd = {16'h0, st_r.curLow};
         dlw_pkg::OFS_CUR_HIGH:  rd = {16'h0, st_r.curHigh};
         dlw_pkg::OFS_FREQ_LOW:  rd = {16'h0, st_r.freqLow};
         dlw_pkg::OFS_FREQ_HIGH: rd = {16'h0, st_r.freqHigh};
         dlw_pkg::OFS_FEEDBACK_WARN_FLOOR:    rd = st_r.fbLow;
         dlw_pkg::OFS_FEEDBACK_WARN_CEILING:   rd = st_r.fbHigh;
         dlw_pkg::OFS_BYP_WIDTH: rd = {16'h0, st_r.bypWidth};
         dlw_pkg::OFS_BYP1:      rd = {16'h0, st_r.byp1};
         dlw_pkg::OFS_BYP2:      rd = {16'h0, st_r.byp2};
         dlw_pkg::OFS_ROUTE_DO:  rd = {26'h0, st_r.routeDo};
         dlw_pkg::OFS_ROUTE_REL: rd = {26'h0, st_r.routeRel};
         dlw_pkg::OFS_STATUS:    rd = {24'h0, st_r.atRef, st_r.syncB[2], warnLive};
         dlw_pkg::OFS_IRQ_STAT:  rd = {26'h0, st_r.irqStat};
         dlw_pkg::OFS_IRQ_MASK:  rd = {26'h0, st_r.irqMask};
         default:                hit = 1'b0;
      endcase
      if (rdSetup) begin
         st_nxt.rdata = hit ? rd : 32'h0000_0000;
         st_nxt.err   = !hit;
      end

      if (wrAcc && !st_r.err) begin
         unique case (paddr)
            dlw_pkg::OFS_CTRL: begin
               st_nxt.wideRange = pwdata[dlw_pkg::CTRL_WIDE_BIT];
               if (!pwdata[dlw_pkg::CTRL_WIDE_BIT] && st_r.freqHigh > dlw_pkg::FREQ_MAX_NARROW) begin
                  st_nxt.freqHigh = dlw_pkg::FREQ_MAX_NARROW;
               end
            end
            dlw_pkg::OFS_CATCH_PCT: st_nxt.catchPct = 14'(clampU(pwdata, 16'h0000, 16'(dlw_pkg::PCT_FULL_SCALE)));
            dlw_pkg::OFS_CUR_CAP:   st_nxt.capPct   = pwdata[15:0];
            dlw_pkg::OFS_RATED_CUR: st_nxt.ratedCur = pwdata[15:0];
            dlw_pkg::OFS_CUR_LOW:   st_nxt.curLow   = clampU(pwdata, 16'h0000, st_r.curHigh);
            dlw_pkg::OFS_CUR_HIGH:  st_nxt.curHigh  = clampU(pwdata, st_r.curLow, 16'hffff);
            dlw_pkg::OFS_FREQ_LOW:  st_nxt.freqLow  = clampU(pwdata, 16'h0000, st_r.freqHigh);
            dlw_pkg::OFS_FREQ_HIGH: st_nxt.freqHigh = clampU(pwdata, st_r.freqLow, fMax);
            dlw_pkg::OFS_FEEDBACK_WARN_FLOOR: begin
               if ($signed(pwdata) > $signed(st_r.fbHigh)) begin
                  st_nxt.fbLow = st_r.fbHigh;
               end else if ($signed(pwdata) < $signed(dlw_pkg::FB_MIN)) begin
                  st_nxt.fbLow = dlw_pkg::FB_MIN;
               end else begin
                  st_nxt.fbLow = pwdata;
               end
            end
            dlw_pkg::OFS_FEEDBACK_WARN_CEILING: begin
               if ($signed(pwdata) < $signed(st_r.fbLow)) begin
                  st_nxt.fbHigh = st_r.fbLow;
               end else if ($signed(pwdata) > $signed(dlw_pkg::FB_MAX)) begin
                  st_nxt.fbHigh = dlw_pkg::FB_MAX;
               end else begin
                  st_nxt.fbHigh = pwdata;
               end
            end
            dlw_pkg::OFS_BYP_WIDTH: st_nxt.bypWidth = clampU(pwdata, 16'h0000, dlw_pkg::BYP_WIDTH_MAX);
            dlw_pkg::OFS_BYP1:      st_nxt.byp1     = clampU(pwdata, 16'h0000, dlw_pkg::BYP_FREQ_MAX);
            dlw_pkg::OFS_BYP2:      st_nxt.byp2     = clampU(pwdata, 16'h0000, dlw_pkg::BYP_FREQ_MAX);
            dlw_pkg::OFS_ROUTE_DO:  st_nxt.routeDo  = pwdata[5:0];
            dlw_pkg::OFS_ROUTE_REL: st_nxt.routeRel = pwdata[5:0];
            dlw_pkg::OFS_IRQ_MASK:  st_nxt.irqMask  = pwdata[5:0];
            default: ;
         endcase
      end

      // Sticky events: write-one clears, a new rising warning wins
      if (wrAcc && paddr == dlw_pkg::OFS_IRQ_STAT) begin
         st_nxt.irqStat = st_r.irqStat & ~pwdata[5:0];
      end
      st_nxt.irqStat = st_nxt.irqStat | (warnLive & ~st_r.warnPrev);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata         = st_r.rdata;
   assign pready         = psel && penable;
   assign pslverr        = psel && penable && st_r.err;
   assign resultRef      = st_r.refOut;
   assign currentCmd     = st_r.curCmd;
   assign warnings       = warnLive;
   assign warnDigitalOut = st_r.doOut;
   assign warnRelayOut   = st_r.relOut;
   assign irq            = |(st_r.irqStat & st_r.irqMask);
endmodule
`default_nettype wire

// file: sim/dlw_monitor.sv
// Port checker for the drive limit and warning supervisor
`timescale 1ns/10ps
`default_nettype none
module dlw_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // Register bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   // Drive side
   input wire logic        runPin,
   input wire logic [15:0] currentDemand,
   input wire logic [15:0] currentCmd,
   input wire logic [5:0]  warnings,
   input wire logic        warnDigitalOut,
   input wire logic        warnRelayOut
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_stopped;
      !runPin [*4];
   endsequence
   property p_ready;
      pready == (psel && penable);
   endproperty
   property p_err;
      pslverr |-> s_access;
   endproperty
   property p_quiet;
      s_stopped |-> warnings == 6'h00;
   endproperty
   property p_route;
      (warnDigitalOut || warnRelayOut) |-> $past(warnings) != 6'h00;
   endproperty
   property p_cap;
      currentCmd <= $past(currentDemand);
   endproperty
   property p_cur_pair;
      !(warnings[0] && warnings[1]);
   endproperty
   property p_freq_pair;
      !(warnings[2] && warnings[3]);
   endproperty
   property p_fb_pair;
      !(warnings[4] && warnings[5]);
   endproperty
   a_ready: assert property (p_ready) else $error("pready not tied to access phase");
   a_err: assert property (p_err) else $error("pslverr outside access phase");
   a_quiet: assert property (p_quiet) else $error("warning while stopped");
   a_route: assert property (p_route) else $error("routed output without warning");
   a_cap: assert property (p_cap) else $error("current command above demand");
   a_cur_pair: assert property (p_cur_pair) else $error("both current warnings");
   a_freq_pair: assert property (p_freq_pair) else $error("both frequency warnings");
   a_fb_pair: assert property (p_fb_pair) else $error("both feedback warnings");
endmodule
bind dlw_supervisor dlw_monitor i_mon (
   .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .runPin(runPin), .currentDemand(currentDemand), .currentCmd(currentCmd), .warnings(warnings),
   .warnDigitalOut(warnDigitalOut), .warnRelayOut(warnRelayOut)
);
`default_nettype wire

// file: sim/dlw_motor_model.sv
// Motor and feedback sensor model facing the supervisor
`timescale 1ns/10ps
`default_nettype none
module dlw_motor_model #(
   parameter logic [15:0] STEP = 16'h0010
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_b,
   // Drive commands
   input  wire logic               runPin,
   input  wire logic [15:0]        resultRef,
   // Load and process level
   input  wire logic [15:0]        loadCur,
   input  wire logic signed [31:0] fbVal,
   // Measurements
   output logic [15:0]             outFreq,
   output logic [15:0]             outCurrent,
   output logic signed [31:0]      feedback
);
   logic [15:0] tgt;
   assign tgt = runPin ? resultRef : 16'h0000;
   // Speed follows in steps so the warnings see a real ramp
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         outFreq <= 16'h0000;
         outCurrent <= 16'h0000;
         feedback <= 32'sh0;
      end else begin
         outCurrent <= loadCur;
         feedback <= fbVal;
         if (outFreq + STEP < tgt) outFreq <= outFreq + STEP;
         else if (outFreq > tgt + STEP) outFreq <= outFreq - STEP;
         else outFreq <= tgt;
      end
   end
endmodule
`default_nettype wire

// file: sim/dlw_supervisor_tb.sv
// Self-checking bench for the drive limit and warning supervisor
`timescale 1ns/10ps
`default_nettype none
module dlw_supervisor_tb;
   logic               clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata;
   logic               catchUpPin, slowDownPin, runPin, warnDigitalOut, warnRelayOut;
   logic [15:0]        remoteRef, outFreq, outCurrent, currentDemand, resultRef, currentCmd, loadCur;
   logic signed [31:0] feedback, fbVal;
   logic [5:0]         warnings;
   int                 errors, cmp_count, expK[$];
   logic [32:0]        expV[$];
   dlw_supervisor i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .catchUpPin(catchUpPin), .slowDownPin(slowDownPin), .runPin(runPin), .remoteRef(remoteRef),
      .outFreq(outFreq), .outCurrent(outCurrent), .currentDemand(currentDemand), .feedback(feedback),
      .resultRef(resultRef), .currentCmd(currentCmd), .warnings(warnings),
      .warnDigitalOut(warnDigitalOut), .warnRelayOut(warnRelayOut), .irq(irq));
   dlw_motor_model i_motor (.clk(clk), .rst_b(rst_b), .runPin(runPin), .resultRef(resultRef),
      .loadCur(loadCur), .fbVal(fbVal), .outFreq(outFreq), .outCurrent(outCurrent), .feedback(feedback));
   task report_and_stop;
      if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task fail(input string m);
      errors++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task cmp_bus(input logic [32:0] e);
      cmp_count++;
      if ({pslverr, prdata} !== e) fail($sformatf("read %h exp %h", {pslverr, prdata}, e));
   endtask
   task cmp_port(input int k, input logic [32:0] e);
      logic [32:0] g;
      g = k == 1 ? 33'(resultRef) : k == 2 ? 33'(currentCmd) : k == 3 ? 33'(warnings) :
          k == 4 ? 33'({warnDigitalOut, warnRelayOut}) : 33'(irq);
      cmp_count++;
      if (g !== e) fail($sformatf("output %0d is %h exp %h", k, g, e));
   endtask
   // Watcher: takes the oldest note whenever its result shows
   always @(posedge clk) begin
      if (psel && penable && !pwrite && expK.size() > 0 && expK[0] == 0) begin
         void'(expK.pop_front());
         cmp_bus(expV.pop_front());
      end else if (expK.size() > 0 && expK[0] != 0) begin
         cmp_port(expK.pop_front(), expV.pop_front());
      end
   end
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail("bus hang");
         report_and_stop();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e);
      expK.push_back(0);
      expV.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task note(input int k, input logic [32:0] e);
      @(negedge clk);
      expK.push_back(k);
      expV.push_back(e);
      @(posedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      logic [7:0]         ra[12] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28,
                                     8'h2c, 8'h30};
      logic [31:0]        rv[12] = '{0, 32'ha0, 32'h64, 0, 32'hffff, 0, 32'h528, 32'hffc2_f700,
                                     32'h003d_0900, 0, 0, 0};
      logic [15:0]        br[6] = '{16'h1e0, 16'h208, 16'h1c2, 16'h316, 16'h32a, 16'h258};
      logic [15:0]        bx[6] = '{16'h1c2, 16'h226, 16'h1c2, 16'h2ee, 16'h352, 16'h258};
      int                 rf, dl, cu, fl, fh, n;
      logic [5:0]         w;
      logic signed [31:0] fbv;
      {rst_b, psel, penable, pwrite, paddr, pwdata, catchUpPin, slowDownPin, runPin} = '0;
      {remoteRef, currentDemand, loadCur, fbVal, errors, cmp_count} = '0;
      void'($urandom(32'h1eb1));
      tick(16);
      rst_b <= 1'b1;
      tick(1);
      foreach (ra[i]) rd(ra[i], {1'b0, rv[i]});
      rd(8'h48, 33'h1_0000_0000);
      wr(dlw_pkg::OFS_FREQ_HIGH, 32'h3000);
      rd(dlw_pkg::OFS_FREQ_HIGH, 33'h528);
      wr(dlw_pkg::OFS_CTRL, 32'h1);
      wr(dlw_pkg::OFS_FREQ_HIGH, 32'h3000);
      rd(dlw_pkg::OFS_FREQ_HIGH, 33'h2710);
      wr(dlw_pkg::OFS_CTRL, 32'h0);
      rd(dlw_pkg::OFS_FREQ_HIGH, 33'h528);
      wr(dlw_pkg::OFS_CUR_HIGH, 32'h100);
      wr(dlw_pkg::OFS_CUR_LOW, 32'h200);
      rd(dlw_pkg::OFS_CUR_LOW, 33'h100);
      // Current limit against demand
      currentDemand <= 16'd500;
      tick(3);
      note(2, 33'ha0);
      wr(dlw_pkg::OFS_CUR_CAP, 32'd50);
      wr(dlw_pkg::OFS_RATED_CUR, 32'd200);
      for (int i = 0; i < 3; i++) begin
         cu = $urandom % 300;
         currentDemand <= 16'(cu);
         tick(3);
         note(2, 33'(cu < 100 ? cu : 100));
      end
      // Trim in every pin combination
      wr(dlw_pkg::OFS_CATCH_PCT, 32'd1000);
      for (int i = 0; i < 8; i++) begin
         rf = 200 + $urandom % 800;
         dl = (rf * 1000 + 5000) / 10000;
         remoteRef <= 16'(rf);
         catchUpPin <= i[0];
         slowDownPin <= i[1];
         tick(4);
         note(1, 33'(i[0] && !i[1] ? rf + dl : i[1] && !i[0] ? rf - dl : rf));
      end
      {catchUpPin, slowDownPin} <= 2'b00;
      // Bypass bands
      wr(dlw_pkg::OFS_BYP1, 32'd500);
      remoteRef <= 16'd480;
      tick(4);
      note(1, 33'd480);
      wr(dlw_pkg::OFS_BYP_WIDTH, 32'h2000);
      rd(dlw_pkg::OFS_BYP_WIDTH, 33'h3e8);
      wr(dlw_pkg::OFS_BYP_WIDTH, 32'd100);
      wr(dlw_pkg::OFS_BYP2, 32'd800);
      foreach (br[i]) begin
         remoteRef <= br[i];
         tick(4);
         note(1, 33'(bx[i]));
      end
      wr(dlw_pkg::OFS_BYP_WIDTH, 32'd0);
      // Warnings across start, run and stop
      wr(dlw_pkg::OFS_CUR_LOW, 32'd50);
      wr(dlw_pkg::OFS_ROUTE_DO, 32'h15);
      wr(dlw_pkg::OFS_ROUTE_REL, 32'h2a);
      wr(dlw_pkg::OFS_IRQ_MASK, 32'h3f);
      {fl, fh} = {32'd0, 32'd1320};
      remoteRef <= 16'd500;
      loadCur <= 16'd10;
      runPin <= 1'b1;
      tick(4);
      note(3, 33'h0);
      n = 0;
      while (outFreq !== resultRef && n < 300) begin
         tick(1);
         n++;
      end
      if (n >= 300) begin
         fail("speed never reached reference");
         report_and_stop();
      end
      tick(3);
      for (int i = 0; i < 8; i++) begin
         if (i == 2) begin
            fl = 600;
            wr(dlw_pkg::OFS_FREQ_LOW, 32'd600);
         end
         if (i == 4) begin
            {fl, fh} = {32'd0, 32'd400};
            wr(dlw_pkg::OFS_FREQ_LOW, 32'd0);
            wr(dlw_pkg::OFS_FREQ_HIGH, 32'd400);
         end
         cu = $urandom % 400;
         fbv = $signed($urandom % 12000000) - 6000000;
         loadCur <= 16'(cu);
         fbVal <= fbv;
         tick(3);
         w = {fbv > 4000000, fbv < -4000000, 500 > fh, 500 < fl, cu > 256, cu < 50};
         note(3, 33'(w));
         note(4, 33'({|(w & 6'h15), |(w & 6'h2a)}));
      end
      // Interrupt raise, mask and clear
      {loadCur, fbVal} <= {16'd100, 32'sd0};
      tick(3);
      wr(dlw_pkg::OFS_IRQ_STAT, 32'h3f);
      rd(dlw_pkg::OFS_IRQ_STAT, 33'h0);
      loadCur <= 16'd10;
      tick(3);
      rd(dlw_pkg::OFS_IRQ_STAT, 33'h1);
      note(5, 33'h1);
      wr(dlw_pkg::OFS_IRQ_MASK, 32'h0);
      note(5, 33'h0);
      wr(dlw_pkg::OFS_IRQ_MASK, 32'h3f);
      wr(dlw_pkg::OFS_IRQ_STAT, 32'h1);
      rd(dlw_pkg::OFS_IRQ_STAT, 33'h0);
      note(5, 33'h0);
      runPin <= 1'b0;
      tick(4);
      note(3, 33'h0);
      note(4, 33'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
